// ### dmcsp_top.sv
// Dual mode SMBus / SPI configuration target port
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - mode strap low selects two-wire target
// - mode strap high selects SPI; others reserved
// - strap pairs form address from 0x0D
// - two-wire clock up to 400 kHz
// - address byte: 7-bit address, direction bit
// - two-wire lines only pulled low
// - nine clocks per byte, ninth acknowledges
// - write: address, register, one data byte
// - read: register, repeated start, data out
// - SPI mode uses in, out, select, clock
// - SPI clock up to 20 MHz
// - SPI frame is seventeen bits under select
// - select high: input ignored, output floated
// - frame: direction, address, data, MSB first
// - previous frame shifts out during new frame
// - output enabled asynchronously on select low
// - write executes when select rises
// - bits transfer on serial clock rising edge
// - read uses two frames, data at end
// - dummy second frame reads address 0xFF
// - chained devices form one long register
// - each device executes its frame at select rise
module dmcsp_top #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 8
) (
    input wire logic REF_CLK_I,
    input wire logic RST_B_I,
    input wire logic CE_I,
    input wire logic MODE_SEL_I,
    input wire logic [1:0] TARGET_ADDRESS_STRAP_HI_I,
    input wire logic [1:0] TARGET_ADDRESS_STRAP_LO_I,
    input wire logic SCL_I,
    output logic SCL_O,
    output logic SCL_OE_B_O,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_B_O,
    input wire logic SPI_SCK_I,
    input wire logic SPI_SS_B_I,
    input wire logic SPI_MOSI_I,
    output logic SPI_MISO_O,
    output logic SPI_MISO_OE_B_O,
    output logic REG_WR_O,
    output logic REG_RD_O,
    output logic [ADDR_W-1:0] REG_ADDR_O,
    output logic [DATA_W-1:0] REG_WDATA_O,
    input wire logic [DATA_W-1:0] REG_RDATA_I,
    output logic SPI_MODE_O,
    output logic [6:0] TARGET_ADDR_O
);
    localparam int FB = dmcsp_pkg::FRAME_BITS;

    // Strap codes stack as {hi, lo} above the base address
    function automatic logic [6:0] strap_address(input logic [1:0] hi,
                                                 input logic [1:0] lo);
        strap_address = dmcsp_pkg::SMB_ADDR_BASE + {3'h0, hi, lo};
    endfunction

    // Frame field decoding; the link side uses only the direction bit, the system side all fields
    function automatic logic frame_is_read(input logic [FB-1:0] f);
        frame_is_read = f[dmcsp_pkg::DIR_POS];
    endfunction

    function automatic logic [7:0] frame_addr(input logic [FB-1:0] f);
        frame_addr = f[dmcsp_pkg::ADDR_LSB +: 8];
    endfunction

    function automatic logic [7:0] frame_data(input logic [FB-1:0] f);
        frame_data = f[dmcsp_pkg::DATA_LSB +: 8];
    endfunction

    // Reset release
    logic rst_s1_reg, rst_b;
    always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rst_s1_reg <= 1'b0;
            rst_b <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_b <= rst_s1_reg;
        end
    end

    // Pin synchronisers
    logic [7:0] pin_s1_reg, pin_s2_reg;
    always_ff @(posedge REF_CLK_I or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1_reg <= 8'hFF;
            pin_s2_reg <= 8'hFF;
        end else if (CE_I) begin
            pin_s1_reg <= {SCL_I, SDA_I, MODE_SEL_I, TARGET_ADDRESS_STRAP_HI_I,
                           TARGET_ADDRESS_STRAP_LO_I, 1'b1};
            pin_s2_reg <= pin_s1_reg;
        end
    end
    logic scl_s, sda_s, mode_s;
    logic [1:0] strap_hi_s, strap_lo_s;
    assign scl_s = pin_s2_reg[7];
    assign sda_s = pin_s2_reg[6];
    assign mode_s = pin_s2_reg[5];
    assign strap_hi_s = pin_s2_reg[4:3];
    assign strap_lo_s = pin_s2_reg[2:1];

    // Straps caught once after reset release
    logic strap_done_reg, spi_mode_reg;
    logic [6:0] my_addr_reg;
    logic [1:0] strap_wait_reg;
    always_ff @(posedge REF_CLK_I or negedge rst_b) begin
        if (!rst_b) begin
            strap_done_reg <= 1'b0;
            strap_wait_reg <= 2'h0;
            spi_mode_reg <= 1'b0;
            my_addr_reg <= dmcsp_pkg::SMB_ADDR_BASE;
        end else if (CE_I && !strap_done_reg) begin
            strap_wait_reg <= strap_wait_reg + 2'h1;
            if (strap_wait_reg == 2'h3) begin
                strap_done_reg <= 1'b1;
                spi_mode_reg <= mode_s;
                my_addr_reg <= strap_address(strap_hi_s, strap_lo_s);
            end
        end
    end
    assign SPI_MODE_O = spi_mode_reg;
    assign TARGET_ADDR_O = my_addr_reg;

    // Two-wire target
    logic scl_d_reg, sda_d_reg;
    always_ff @(posedge REF_CLK_I or negedge rst_b) begin
        if (!rst_b) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else if (CE_I) begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end
    logic smb_en, scl_rise, scl_fall, start_c, stop_c;
    assign smb_en = strap_done_reg && !spi_mode_reg;
    assign scl_rise = scl_s && !scl_d_reg;
    assign scl_fall = !scl_s && scl_d_reg;
    // Both samples need SCL high, so data moving while SCL is low is
    // never taken for a start or a stop
    assign start_c = scl_s && scl_d_reg && sda_d_reg && !sda_s;
    assign stop_c = scl_s && scl_d_reg && !sda_d_reg && sda_s;

    dmcsp_pkg::dmcsp_smb_e st_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] sh_reg;
    logic sda_low_reg, rd_dir_reg, smb_wr_reg, smb_rd_reg;
    logic [7:0] smb_addr_reg, smb_data_reg;
    always_ff @(posedge REF_CLK_I or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= dmcsp_pkg::SMB_IDLE;
            bit_cnt_reg <= dmcsp_pkg::BIT_CNT_RST;
            sh_reg <= 8'h00;
            sda_low_reg <= 1'b0;
            rd_dir_reg <= 1'b0;
            smb_wr_reg <= 1'b0;
            smb_rd_reg <= 1'b0;
            smb_addr_reg <= 8'h00;
            smb_data_reg <= 8'h00;
        end else if (CE_I) begin
            smb_wr_reg <= 1'b0;
            smb_rd_reg <= 1'b0;
            if (!smb_en || stop_c) begin
                st_reg <= dmcsp_pkg::SMB_IDLE;
                sda_low_reg <= 1'b0;
            end else if (start_c) begin
                st_reg <= dmcsp_pkg::SMB_ADDR; // repeated start too
                bit_cnt_reg <= dmcsp_pkg::BIT_CNT_RST;
                sda_low_reg <= 1'b0;
            end else begin
                case (st_reg)
                    dmcsp_pkg::SMB_IDLE: begin
                        // Wait for a start condition
                    end
                    dmcsp_pkg::SMB_ADDR, dmcsp_pkg::SMB_REG,
                    dmcsp_pkg::SMB_WDATA: begin
                        if (scl_rise) begin
                            sh_reg <= {sh_reg[6:0], sda_s};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                        if (scl_fall && bit_cnt_reg == 4'h8) begin
                            bit_cnt_reg <= dmcsp_pkg::BIT_CNT_RST;
                            if (st_reg == dmcsp_pkg::SMB_ADDR) begin
                                if (sh_reg[7:1] == my_addr_reg) begin
                                    rd_dir_reg <= sh_reg[0];
                                    sda_low_reg <= 1'b1;
                                    st_reg <= dmcsp_pkg::SMB_ADDR_ACK;
                                    if (sh_reg[0]) begin
                                        smb_rd_reg <= 1'b1;
                                    end
                                end else begin
                                    st_reg <= dmcsp_pkg::SMB_IDLE;
                                end
                            end else if (st_reg == dmcsp_pkg::SMB_REG) begin
                                smb_addr_reg <= sh_reg;
                                sda_low_reg <= 1'b1;
                                st_reg <= dmcsp_pkg::SMB_REG_ACK;
                            end else begin
                                smb_data_reg <= sh_reg;
                                smb_wr_reg <= 1'b1;
                                sda_low_reg <= 1'b1;
                                st_reg <= dmcsp_pkg::SMB_WDATA_ACK;
                            end
                        end
                    end
                    dmcsp_pkg::SMB_ADDR_ACK: begin
                        if (scl_fall) begin
                            if (rd_dir_reg) begin
                                sh_reg <= REG_RDATA_I;
                                sda_low_reg <= !REG_RDATA_I[7];
                                bit_cnt_reg <= 4'h1;
                                st_reg <= dmcsp_pkg::SMB_RDATA;
                            end else begin
                                sda_low_reg <= 1'b0;
                                st_reg <= dmcsp_pkg::SMB_REG;
                            end
                        end
                    end
                    dmcsp_pkg::SMB_REG_ACK, dmcsp_pkg::SMB_WDATA_ACK: begin
                        if (scl_fall) begin
                            sda_low_reg <= 1'b0;
                            st_reg <= dmcsp_pkg::SMB_WDATA;
                        end
                    end
                    dmcsp_pkg::SMB_RDATA: begin
                        if (scl_fall) begin
                            if (bit_cnt_reg == 4'h8) begin
                                sda_low_reg <= 1'b0;
                                st_reg <= dmcsp_pkg::SMB_RDATA_ACK;
                            end else begin
                                sda_low_reg <= !sh_reg[3'h7 - bit_cnt_reg[2:0]];
                                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            end
                        end
                    end
                    dmcsp_pkg::SMB_RDATA_ACK: begin
                        if (scl_rise) begin
                            // Master NACK ends the read
                            st_reg <= sda_s ? dmcsp_pkg::SMB_IDLE
                                            : dmcsp_pkg::SMB_RDATA_ACK;
                        end
                        if (scl_fall) begin
                            sh_reg <= REG_RDATA_I;
                            sda_low_reg <= !REG_RDATA_I[7];
                            bit_cnt_reg <= 4'h1;
                            st_reg <= dmcsp_pkg::SMB_RDATA;
                        end
                    end
                    default: st_reg <= dmcsp_pkg::SMB_IDLE;
                endcase
            end
        end
    end
    // Open drain: only ever drive low
    assign SDA_O = 1'b0;
    assign SDA_OE_B_O = !sda_low_reg;
    assign SCL_O = 1'b0;
    assign SCL_OE_B_O = 1'b1;

    // SPI link domain, clocked by the host serial clock and by select
    logic [FB-1:0] spi_sh_reg;
    logic [FB-1:0] spi_hold_reg;
    logic [4:0] spi_cnt_reg;
    logic [7:0] rd_back_reg;
    logic first_bit, merge_rd;
    // Clocks seen in this frame; select high clears it, so it only counts
    // while a frame is open, and it saturates for long chains
    always_ff @(posedge SPI_SCK_I or posedge SPI_SS_B_I) begin
        if (SPI_SS_B_I) begin
            spi_cnt_reg <= dmcsp_pkg::SPI_CNT_RST;
        end else if (spi_cnt_reg != 5'h1F) begin
            spi_cnt_reg <= spi_cnt_reg + 5'h01;
        end
    end
    assign first_bit = (spi_cnt_reg == dmcsp_pkg::SPI_CNT_RST);
    // After a read frame the fetched byte replaces the data field on the
    // first clock of the next frame, so it leaves in the last eight slots.
    // The byte is quasi-static: it settles a few system clocks after select
    // rises, so select must stay high for at least eight system clocks.
    assign merge_rd = first_bit && frame_is_read(spi_hold_reg);
    always_ff @(posedge SPI_SCK_I or negedge rst_b) begin
        if (!rst_b) begin
            spi_sh_reg <= '0;
        end else if (!SPI_SS_B_I) begin
            if (merge_rd) begin
                spi_sh_reg <= {spi_sh_reg[FB-2:dmcsp_pkg::ADDR_LSB],
                               rd_back_reg, SPI_MOSI_I};
            end else begin
                spi_sh_reg <= {spi_sh_reg[FB-2:0], SPI_MOSI_I};
            end
        end
    end
    // Frame captured as select rises; held stable until the next frame
    always_ff @(posedge SPI_SS_B_I or negedge rst_b) begin
        if (!rst_b) begin
            spi_hold_reg <= '0;
        end else begin
            spi_hold_reg <= spi_sh_reg;
        end
    end
    // One toggle per frame end; the system side turns each change into
    // a single event
    logic ss_tog_reg;
    always_ff @(posedge SPI_SS_B_I or negedge rst_b) begin
        if (!rst_b) begin
            ss_tog_reg <= 1'b0;
        end else begin
            ss_tog_reg <= !ss_tog_reg;
        end
    end
    // The previous frame leaves MSB first; the first bit stands as soon as
    // select falls, each later one after the rising edge that shifts it
    assign SPI_MISO_O = SPI_SS_B_I ? 1'b0 : spi_sh_reg[FB-1];
    assign SPI_MISO_OE_B_O = SPI_SS_B_I || !spi_mode_reg;

    // Frame-end event crosses by toggle: two stages settle it and the
    // third holds the previous value for the change detect
    logic tog_s1_reg, tog_s2_reg, tog_s3_reg;
    always_ff @(posedge REF_CLK_I or negedge rst_b) begin
        if (!rst_b) begin
            tog_s1_reg <= 1'b0;
            tog_s2_reg <= 1'b0;
            tog_s3_reg <= 1'b0;
        end else if (CE_I) begin
            tog_s1_reg <= ss_tog_reg;
            tog_s2_reg <= tog_s1_reg;
            tog_s3_reg <= tog_s2_reg;
        end
    end
    logic spi_evt;
    assign spi_evt = (tog_s2_reg != tog_s3_reg) && strap_done_reg
        && spi_mode_reg;

    // Register access port
    always_ff @(posedge REF_CLK_I or negedge rst_b) begin
        if (!rst_b) begin
            REG_WR_O <= 1'b0;
            REG_RD_O <= 1'b0;
            REG_ADDR_O <= '0;
            REG_WDATA_O <= '0;
            rd_back_reg <= 8'h00;
        end else if (CE_I) begin
            REG_WR_O <= 1'b0;
            REG_RD_O <= 1'b0;
            if (spi_evt) begin
                REG_ADDR_O <= frame_addr(spi_hold_reg);
                REG_WDATA_O <= frame_data(spi_hold_reg);
                REG_WR_O <= !frame_is_read(spi_hold_reg);
                REG_RD_O <= frame_is_read(spi_hold_reg);
            end else if (smb_wr_reg) begin
                REG_ADDR_O <= smb_addr_reg;
                REG_WDATA_O <= smb_data_reg;
                REG_WR_O <= 1'b1;
            end else if (smb_rd_reg) begin
                REG_ADDR_O <= smb_addr_reg;
                REG_RD_O <= 1'b1;
            end
            // Kept for the next SPI frame to shift out
            if (REG_RD_O) begin
                rd_back_reg <= REG_RDATA_I;
            end
        end
    end
endmodule
`default_nettype wire

// ### dmcsp_pkg.sv
// Constants shared by the dual mode configuration serial port
package dmcsp_pkg;
    localparam int FRAME_BITS = 17;
    localparam logic [6:0] SMB_ADDR_BASE = 7'h0D;
    localparam logic [1:0] STRAP_1K_GND = 2'h0;
    localparam logic [1:0] STRAP_20K_GND = 2'h1;
    localparam logic [1:0] STRAP_FLOAT = 2'h2;
    localparam logic [1:0] STRAP_1K_VDD = 2'h3;
    localparam logic [7:0] DUMMY_READ_ADDR = 8'hFF;
    localparam int SMB_MAX_KHZ = 400;
    localparam int SPI_MAX_MHZ = 20;
    localparam logic [3:0] BIT_CNT_RST = 4'h0;
    localparam logic [4:0] SPI_CNT_RST = 5'h00;
    localparam int DIR_POS = 16;
    localparam int ADDR_LSB = 8;
    localparam int DATA_LSB = 0;
    typedef enum {
        SMB_IDLE, SMB_ADDR, SMB_ADDR_ACK, SMB_REG, SMB_REG_ACK,
        SMB_WDATA, SMB_WDATA_ACK, SMB_RDATA, SMB_RDATA_ACK
    } dmcsp_smb_e;
endpackage

// ### dmcsp_props.sv
// Port checker for the dual mode serial port
`timescale 1ns/100ps
`default_nettype none
module dmcsp_props (
    input wire logic REF_CLK_I,
    input wire logic RST_B_I,
    input wire logic MODE_SEL_I,
    input wire logic [1:0] TARGET_ADDRESS_STRAP_HI_I,
    input wire logic [1:0] TARGET_ADDRESS_STRAP_LO_I,
    input wire logic SCL_O,
    input wire logic SCL_OE_B_O,
    input wire logic SDA_O,
    input wire logic SDA_OE_B_O,
    input wire logic SPI_SS_B_I,
    input wire logic SPI_MISO_OE_B_O,
    input wire logic REG_WR_O,
    input wire logic REG_RD_O,
    input wire logic SPI_MODE_O,
    input wire logic [6:0] TARGET_ADDR_O
);
    logic [3:0] up_reg;
    logic [6:0] exp_addr;
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_B_I);
    assign exp_addr = dmcsp_pkg::SMB_ADDR_BASE
        + {3'h0, TARGET_ADDRESS_STRAP_HI_I, TARGET_ADDRESS_STRAP_LO_I};
    // Cycles since reset release, saturating
    always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            up_reg <= 4'h0;
        end else if (up_reg != 4'hF) begin
            up_reg <= up_reg + 4'h1;
        end
    end
    mode_strap_a: assert property (up_reg == 4'hE |->
        SPI_MODE_O == MODE_SEL_I) else $error("mode strap");
    addr_strap_a: assert property (up_reg == 4'hE && !MODE_SEL_I |->
        TARGET_ADDR_O == exp_addr) else $error("address strap");
    open_drain_a: assert property (SCL_OE_B_O && !SCL_O &&
        (SDA_OE_B_O || !SDA_O)) else $error("line driven high");
    miso_float_a: assert property (SPI_SS_B_I |->
        SPI_MISO_OE_B_O) else $error("data out not floated");
    miso_enable_a: assert property (!SPI_SS_B_I && SPI_MODE_O |->
        !SPI_MISO_OE_B_O) else $error("data out not enabled");
    frame_exec_a: assert property (SPI_MODE_O && $rose(SPI_SS_B_I) |->
        ##[1:8] (REG_WR_O || REG_RD_O)) else $error("frame not run");
    exec_idle_a: assert property (REG_WR_O && SPI_MODE_O |->
        SPI_SS_B_I) else $error("write while selected");
    spi_sda_a: assert property (SPI_MODE_O |-> SDA_OE_B_O
        && (up_reg != 4'hF || $stable(SPI_MODE_O)))
        else $error("data line in spi mode");
    wr_cov: cover property (REG_WR_O);
    rd_cov: cover property (REG_RD_O);
    ack_cov: cover property (!SDA_OE_B_O);
endmodule
`default_nettype wire

// ### dmcsp_host_model.sv
// Host controller model for the two-wire and SPI sides
`timescale 1ns/100ps
`default_nettype none
module dmcsp_host_model (
    input wire logic clk_i,
    input wire logic sda_i,
    input wire logic miso_i,
    output logic scl_low_o,
    output logic sda_low_o,
    output logic sck_o,
    output logic ss_b_o,
    output logic mosi_o
);
    initial begin
        scl_low_o = 1'b0;
        sda_low_o = 1'b0;
        sck_o = 1'b0;
        ss_b_o = 1'b1;
        mosi_o = 1'b0;
    end
    // Start and repeated start, clock left low; 400 kHz bit rate
    task automatic smb_start();
        sda_low_o <= 1'b0;
        repeat (62) @(posedge clk_i);
        scl_low_o <= 1'b0;
        repeat (62) @(posedge clk_i);
        sda_low_o <= 1'b1;
        repeat (63) @(posedge clk_i);
        scl_low_o <= 1'b1;
        repeat (63) @(posedge clk_i);
    endtask
    task automatic smb_stop();
        sda_low_o <= 1'b1;
        repeat (62) @(posedge clk_i);
        scl_low_o <= 1'b0;
        repeat (62) @(posedge clk_i);
        sda_low_o <= 1'b0;
        repeat (63) @(posedge clk_i);
    endtask
    // Eight data clocks then the acknowledge clock, MSB first
    task automatic smb_byte(input logic [7:0] tx, input logic host_ack,
                            output logic [7:0] rx, output logic ack);
        for (int i = 8; i >= 0; i--) begin
            sda_low_o <= (i > 0) ? !tx[i-1] : host_ack;
            repeat (62) @(posedge clk_i);
            scl_low_o <= 1'b0;
            repeat (125) @(posedge clk_i);
            if (i > 0) begin
                rx[i-1] = sda_i;
            end else begin
                ack = !sda_i;
            end
            scl_low_o <= 1'b1;
            repeat (63) @(posedge clk_i);
        end
    endtask
    // Link clock runs only inside the frame, 80 ns period
    task automatic spi_xfer(input logic [33:0] tx, input int n,
                            output logic [33:0] rx);
        rx = '0;
        ss_b_o <= 1'b0;
        #37;
        for (int i = n - 1; i >= 0; i--) begin
            mosi_o <= tx[i];
            #40 rx = {rx[32:0], miso_i};
            sck_o <= 1'b1;
            #40 sck_o <= 1'b0;
        end
        #40 ss_b_o <= 1'b1;
        mosi_o <= !mosi_o;
        #80;
    endtask
endmodule
`default_nettype wire

// ### dmcsp_top_tb.sv
// Self-checking bench for the dual mode serial port
`timescale 1ns/100ps
`default_nettype none
module dmcsp_top_tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic mode_sel = 1'b0;
    logic scl_low, sda_low, sck, ss_b, mosi, sda_o, sda_oe_b, scl_oe_b;
    logic miso, miso_oe_b, wr, rd, spi_mode;
    logic [7:0] addr, wdata, wr_a, wr_d, rd_a;
    logic [6:0] tgt;
    logic [33:0] rx;
    wire [7:0] rdata = addr ^ 8'hA5;
    int failures = 0;
    int tests_run = 0;
    int wr_cnt = 0;
    int rd_cnt = 0;
    int cyc = 0;
    wire scl_w = !(scl_low || !scl_oe_b);
    wire sda_w = !(sda_low || (!sda_oe_b && !sda_o));
    wire miso_w = miso_oe_b ? !miso : miso;
    initial begin
        forever #5 clk = ~clk;
    end
    dmcsp_top i_dut (.REF_CLK_I(clk), .RST_B_I(rst_b), .CE_I(1'b1),
        .MODE_SEL_I(mode_sel), .TARGET_ADDRESS_STRAP_HI_I(2'h2),
        .TARGET_ADDRESS_STRAP_LO_I(2'h1), .SCL_I(scl_w), .SCL_O(),
        .SCL_OE_B_O(scl_oe_b), .SDA_I(sda_w), .SDA_O(sda_o),
        .SDA_OE_B_O(sda_oe_b), .SPI_SCK_I(sck), .SPI_SS_B_I(ss_b),
        .SPI_MOSI_I(mosi), .SPI_MISO_O(miso), .SPI_MISO_OE_B_O(miso_oe_b),
        .REG_WR_O(wr), .REG_RD_O(rd), .REG_ADDR_O(addr),
        .REG_WDATA_O(wdata), .REG_RDATA_I(rdata), .SPI_MODE_O(spi_mode),
        .TARGET_ADDR_O(tgt));
    dmcsp_host_model i_host (.clk_i(clk), .sda_i(sda_w), .miso_i(miso_w),
        .scl_low_o(scl_low), .sda_low_o(sda_low), .sck_o(sck),
        .ss_b_o(ss_b), .mosi_o(mosi));
    // Register file stand-in and strobe capture
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (wr === 1'b1) begin
            wr_cnt <= wr_cnt + 1;
            wr_a <= addr;
            wr_d <= wdata;
        end
        if (rd === 1'b1) begin
            rd_cnt <= rd_cnt + 1;
            rd_a <= addr;
        end
        if (cyc == 60000) begin
            failures = failures + 1;
            summarize();
        end
    end
    task automatic summarize();
        $display("tests run %0d, failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic do_reset(input logic mode);
        rst_b <= 1'b0;
        mode_sel <= mode;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (14) @(posedge clk);
        chk({spi_mode, tgt}, {mode, 7'h16});
    endtask
    task automatic smb_send(input logic [7:0] b, input logic exp_ack);
        logic [7:0] r;
        logic a;
        i_host.smb_byte(b, 1'b0, r, a);
        chk(a, exp_ack);
    endtask
    task automatic test_smb();
        logic [7:0] r;
        logic a;
        int w0;
        w0 = wr_cnt;
        i_host.smb_start();
        smb_send(8'h2C, 1'b1);
        smb_send(8'h5A, 1'b1);
        smb_send(8'hC3, 1'b1);
        i_host.smb_stop();
        chk({wr_a, wr_d, 8'(wr_cnt - w0)}, 24'h5AC301);
        i_host.smb_start();
        smb_send(8'h2C, 1'b1);
        smb_send(8'h3C, 1'b1);
        i_host.smb_start();
        smb_send(8'h2D, 1'b1);
        i_host.smb_byte(8'hFF, 1'b0, r, a);
        i_host.smb_stop();
        chk({r, rd_a}, 16'h993C);
        i_host.smb_start();
        smb_send(8'h2E, 1'b0);
        i_host.smb_stop();
        chk(wr_cnt - w0, 1);
        $display("two-wire test done");
    endtask
    task automatic test_spi();
        int w0;
        int r0;
        w0 = wr_cnt;
        r0 = rd_cnt;
        i_host.spi_xfer(34'h0125A, 17, rx);
        repeat (10) @(posedge clk);
        chk({wr_a, wr_d, 8'(wr_cnt - w0)}, 24'h125A01);
        i_host.spi_xfer(34'h155FF, 17, rx);
        chk(rx, 34'h0125A);
        i_host.spi_xfer(34'h1FFFF, 17, rx);
        repeat (10) @(posedge clk);
        chk(rx, 34'h155F0);
        chk({rd_a, 8'(rd_cnt - r0)}, 16'hFF02);
        i_host.spi_xfer({17'h07711, 17'h06622}, 34, rx);
        repeat (10) @(posedge clk);
        chk(rx, {17'h1FF5A, 17'h07711});
        chk({wr_a, wr_d, 8'(wr_cnt - w0)}, 24'h662202);
        $display("spi test done");
    endtask
    initial begin
        do_reset(1'b0);
        test_smb();
        do_reset(1'b1);
        test_spi();
        summarize();
    end
endmodule
bind dmcsp_top dmcsp_props i_props (.REF_CLK_I(REF_CLK_I),
    .RST_B_I(RST_B_I), .MODE_SEL_I(MODE_SEL_I),
    .TARGET_ADDRESS_STRAP_HI_I(TARGET_ADDRESS_STRAP_HI_I),
    .TARGET_ADDRESS_STRAP_LO_I(TARGET_ADDRESS_STRAP_LO_I),
    .SCL_O(SCL_O), .SCL_OE_B_O(SCL_OE_B_O), .SDA_O(SDA_O),
    .SDA_OE_B_O(SDA_OE_B_O),
    .SPI_SS_B_I(SPI_SS_B_I), .SPI_MISO_OE_B_O(SPI_MISO_OE_B_O),
    .REG_WR_O(REG_WR_O), .REG_RD_O(REG_RD_O), .SPI_MODE_O(SPI_MODE_O),
    .TARGET_ADDR_O(TARGET_ADDR_O));
`default_nettype wire
